// >>> include/rcb_pkg.sv
package rcb_pkg;

    // -----------------------------------------------------------------
    // register offsets (plain port, word index)
    // -----------------------------------------------------------------
    localparam logic [3:0] RCB_ADDR_CAUSE = 4'h0;   // reset_cause_flags
    localparam logic [3:0] RCB_ADDR_BOOT = 4'h1;    // boot_select_config
    localparam logic [3:0] RCB_ADDR_PERIPH = 4'h2;  // software peripheral reset select
    localparam logic [3:0] RCB_ADDR_CTRL = 4'h3;    // system request and remap control
    localparam logic [3:0] RCB_ADDR_IRQ_ST = 4'h4;  // event status, cleared on read
    localparam logic [3:0] RCB_ADDR_IRQ_MASK = 4'h5; // event mask
    localparam logic [3:0] RCB_ADDR_STATUS = 4'h6;  // boot state and outcome

    // -----------------------------------------------------------------
    // reset cause bit positions
    // -----------------------------------------------------------------
    localparam int RCB_CAUSE_W = 6;
    localparam int RCB_C_POR = 0;
    localparam int RCB_C_EXT = 1;
    localparam int RCB_C_DROOP = 2;
    localparam int RCB_C_SW = 3;
    localparam int RCB_C_WDOG = 4;
    localparam int RCB_C_OSC = 5;
    localparam logic [RCB_CAUSE_W-1:0] RCB_CAUSE_RST = 6'h01; // power-on leaves only its own flag

    // -----------------------------------------------------------------
    // boot_select_config fields
    // -----------------------------------------------------------------
    localparam int RCB_BOOT_EN = 0;       // enable pin check
    localparam int RCB_BOOT_POL = 1;      // level that selects the loader
    localparam int RCB_BOOT_PIN_LSB = 2;  // pin index field
    localparam logic [31:0] RCB_BOOT_RST = 32'hffff_fffe;

    // -----------------------------------------------------------------
    // control register bits, flash addresses, timing
    // -----------------------------------------------------------------
    localparam int RCB_CTRL_SYSREQ = 0;   // system_reset_request, self clearing
    localparam int RCB_CTRL_REMAP = 1;    // rom overlay status / write one to clear
    localparam logic [31:0] RCB_SP_ADDR = 32'h0000_0000;
    localparam logic [31:0] RCB_VEC_ADDR = 32'h0000_0004;
    localparam logic [31:0] RCB_BLANK = 32'hffff_ffff;
    localparam int RCB_SYNC_STAGES = 3;
    localparam int RCB_CLK_MHZ = 50;

    // -----------------------------------------------------------------
    // boot sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        RCB_ST_RESET,
        RCB_ST_UNMAP,
        RCB_ST_PIN,
        RCB_ST_VEC,
        RCB_ST_SP,
        RCB_ST_LOADER,
        RCB_ST_RUN
    } rcb_state_e;

endpackage : rcb_pkg

// >>> verilog/rcb_reset_ctrl.sv
// Overview of operation
// - six independent reset request inputs accepted
// - por droop sw wdog osc reset everything
// - peripheral reset only selected blocks, core runs
// - external pin resets core, peripherals, not tap
// - set cause flag of the reset source
// - flags sticky; por clears others, sets own
// - write zero clears flag, one keeps it
// - core reset overlays rom on flash
// - boot first clears remap, flash at zero
// - enabled boot pin matching polarity enters loader
// - blank reset vector enters loader
// - valid vector loads pc then sp, run
// - por resets all logic including tap
// - hold reset until por inactive, then fetch
// - por request only on initial power-up
// - reset held while external pin asserted
module rcb_reset_ctrl
#(
    parameter int PERIPH_W = 32,   // number of peripheral reset lines
    parameter int GPIO_W = 64      // number of selectable boot pins
)
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic rst_n,
    // reset requests
    input wire logic ext_reset_n,
    input wire logic supply_droop_reset,
    input wire logic wdog_reset,
    input wire logic main_oscillator_fail,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // boot inputs
    input wire logic [GPIO_W-1:0] gpio_in,
    output logic flash_rd,
    output logic [31:0] flash_addr,
    input wire logic [31:0] flash_rdata,
    // reset outputs
    output logic core_reset_n,
    output logic tap_reset_n,
    output logic [PERIPH_W-1:0] periph_reset_n,
    // boot results
    output logic rom_remap,
    output logic boot_done,
    output logic boot_loader,
    output logic [31:0] boot_sp,
    output logic [31:0] boot_pc,
    // interrupt
    output logic irq
);
    import rcb_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [RCB_CAUSE_W-1:0] cause_ff;          // sticky reset cause flags
    logic [RCB_CAUSE_W-1:0] nxt_cause;
    logic [31:0] boot_cfg_ff;                  // boot_select_config
    logic [PERIPH_W-1:0] periph_sel_ff;        // software peripheral reset select
    logic sysreq_ff;                           // one-cycle system request
    logic [RCB_SYNC_STAGES-1:0] sys_sync_ff;   // system reset release chain
    logic [RCB_SYNC_STAGES-1:0] tap_sync_ff;   // tap reset release chain
    logic [RCB_CAUSE_W-1:0] pend_ff;           // causes seen during current reset
    logic [1:0] st_ev_ff;                      // event status: boot done, loader
    logic [1:0] mask_ff;                       // event mask
    rcb_state_e state_ff;
    rcb_state_e nxt_state;
    logic [31:0] rdata_ff;
    logic [31:0] sp_ff;
    logic [31:0] pc_ff;
    logic remap_ff;
    logic loader_ff;
    logic done_ff;

    // -----------------------------------------------------------------
    // reset source combination
    // -----------------------------------------------------------------
    // full-system requests (not the pin, which spares the tap)
    wire sys_req = supply_droop_reset | wdog_reset | main_oscillator_fail | sysreq_ff;
    // anything besides power-on that resets the core
    wire core_req = sys_req | ~ext_reset_n;
    // core reset released synchronously from the last stage
    wire core_rel = sys_sync_ff[RCB_SYNC_STAGES-1];
    wire tap_rel = tap_sync_ff[RCB_SYNC_STAGES-1];
    wire [RCB_CAUSE_W-1:0] req_vec;
    assign req_vec[RCB_C_POR] = 1'b0;
    assign req_vec[RCB_C_EXT] = ~ext_reset_n;
    assign req_vec[RCB_C_DROOP] = supply_droop_reset;
    assign req_vec[RCB_C_SW] = sysreq_ff;
    assign req_vec[RCB_C_WDOG] = wdog_reset;
    assign req_vec[RCB_C_OSC] = main_oscillator_fail;

    // -----------------------------------------------------------------
    // reset release synchronisers
    // -----------------------------------------------------------------
    // tap chain: only power-on and full-system requests reset it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tap_sync_ff <= '0;
        else if (sys_req)
            tap_sync_ff <= '0;
        else
            tap_sync_ff <= {tap_sync_ff[RCB_SYNC_STAGES-2:0], 1'b1};
    end

    // core chain: also held by the external pin
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sys_sync_ff <= '0;
        else if (core_req)
            sys_sync_ff <= '0;
        else
            sys_sync_ff <= {sys_sync_ff[RCB_SYNC_STAGES-2:0], 1'b1};
    end

    // -----------------------------------------------------------------
    // reset outputs
    // -----------------------------------------------------------------
    assign core_reset_n = core_rel;
    assign tap_reset_n = tap_rel;
    // peripherals follow the core reset plus their own select bit
    assign periph_reset_n = {PERIPH_W{core_rel}} & ~periph_sel_ff;

    // -----------------------------------------------------------------
    // register decode
    // -----------------------------------------------------------------
    // write strobes per register word
    wire wr_cause = reg_wr & (reg_addr == RCB_ADDR_CAUSE);
    wire wr_boot = reg_wr & (reg_addr == RCB_ADDR_BOOT);
    wire wr_periph = reg_wr & (reg_addr == RCB_ADDR_PERIPH);
    wire wr_ctrl = reg_wr & (reg_addr == RCB_ADDR_CTRL);
    wire wr_mask = reg_wr & (reg_addr == RCB_ADDR_IRQ_MASK);
    wire rd_st = reg_rd & (reg_addr == RCB_ADDR_IRQ_ST);
    logic [31:0] rd_mux;
    // read selection; unmapped words read zero
    always_comb
    begin
        if (reg_addr == RCB_ADDR_CAUSE)
            rd_mux = {{(32-RCB_CAUSE_W){1'b0}}, cause_ff};
        else if (reg_addr == RCB_ADDR_BOOT)
            rd_mux = boot_cfg_ff;
        else if (reg_addr == RCB_ADDR_PERIPH)
            rd_mux = 32'(periph_sel_ff);
        else if (reg_addr == RCB_ADDR_CTRL)
            rd_mux = {30'h0, remap_ff, 1'b0};
        else if (reg_addr == RCB_ADDR_IRQ_ST)
            rd_mux = {30'h0, st_ev_ff};
        else if (reg_addr == RCB_ADDR_IRQ_MASK)
            rd_mux = {30'h0, mask_ff};
        else if (reg_addr == RCB_ADDR_STATUS)
            rd_mux = {27'h0, loader_ff, done_ff, 3'(state_ff)};
        else
            rd_mux = 32'h0000_0000;            // unmapped reads zero
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
            rdata_ff <= rd_mux;
        else
            rdata_ff <= 32'h0000_0000;
    end
    assign reg_rdata = rdata_ff;

    // -----------------------------------------------------------------
    // reset cause flags
    // -----------------------------------------------------------------
    // causes set as seen and also latched while reset is held, applied again at release
    // a cause that drops before release is still recorded
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pend_ff <= '0;
        else if (core_rel)
            pend_ff <= req_vec;
        else
            pend_ff <= pend_ff | req_vec;
    end

    // write zero clears; a new cause wins over the clear
    always_comb
    begin
        nxt_cause = cause_ff;
        if (wr_cause)
            nxt_cause = cause_ff & reg_wdata[RCB_CAUSE_W-1:0];
        if (core_rel)
            nxt_cause = nxt_cause | pend_ff | req_vec;
        else
            nxt_cause = nxt_cause | req_vec;
    end

    // power-on only comes through rst_n, once per supply
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cause_ff <= RCB_CAUSE_RST;
        else
            cause_ff <= nxt_cause;
    end

    // -----------------------------------------------------------------
    // software control registers
    // -----------------------------------------------------------------
    // boot config and peripheral select survive core resets
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_cfg_ff <= RCB_BOOT_RST;
            periph_sel_ff <= '0;
            mask_ff <= 2'h0;
        end
        else
        begin
            if (wr_boot)
                boot_cfg_ff <= reg_wdata;
            if (wr_periph)
                periph_sel_ff <= reg_wdata[PERIPH_W-1:0];
            if (wr_mask)
                mask_ff <= reg_wdata[1:0];
        end
    end

    // system request pulse, cleared as soon as it takes effect
    // gated by core_rel so a write during reset cannot re-arm it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sysreq_ff <= 1'b0;
        else
            sysreq_ff <= wr_ctrl & reg_wdata[RCB_CTRL_SYSREQ] & core_rel;
    end

    // -----------------------------------------------------------------
    // decode helpers
    // -----------------------------------------------------------------
    // true for the two states that end the boot decision
    function automatic logic is_final(input rcb_state_e st);
        return (st == RCB_ST_LOADER) || (st == RCB_ST_RUN);
    endfunction : is_final

    // -----------------------------------------------------------------
    // boot sequencer
    // -----------------------------------------------------------------
    // pin index truncated to the gpio width in use
    wire [5:0] pin_idx = boot_cfg_ff[RCB_BOOT_PIN_LSB +: 6];
    wire pin_lvl = gpio_in[pin_idx[$clog2(GPIO_W)-1:0]];
    wire pin_hit = boot_cfg_ff[RCB_BOOT_EN] & (pin_lvl == boot_cfg_ff[RCB_BOOT_POL]);

    // walk: reset, unmap, pin, vector, stack word, run; pin or vector can branch to loader
    // next state of the boot decision
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            RCB_ST_RESET: nxt_state = core_rel ? RCB_ST_UNMAP : RCB_ST_RESET;
            RCB_ST_UNMAP: nxt_state = RCB_ST_PIN;
            RCB_ST_PIN: nxt_state = pin_hit ? RCB_ST_LOADER : RCB_ST_VEC;
            RCB_ST_VEC: nxt_state = (flash_rdata == RCB_BLANK) ? RCB_ST_LOADER : RCB_ST_SP;
            RCB_ST_SP: nxt_state = RCB_ST_RUN;
            default: nxt_state = state_ff;
        endcase
        // any drop of the core reset restarts the decision from the top
        if (!core_rel)
            nxt_state = RCB_ST_RESET;
    end

    // state, overlay and loaded words
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= RCB_ST_RESET;
            remap_ff <= 1'b1;
            sp_ff <= 32'h0000_0000;
            pc_ff <= 32'h0000_0000;
            loader_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (!core_rel)
            begin
                remap_ff <= 1'b1;
                loader_ff <= 1'b0;
                done_ff <= 1'b0;
            end
            else
            begin
                if (state_ff == RCB_ST_UNMAP)
                    remap_ff <= 1'b0;
                else if (wr_ctrl & reg_wdata[RCB_CTRL_REMAP])
                    remap_ff <= 1'b0;
                if (state_ff == RCB_ST_VEC)
                    pc_ff <= flash_rdata;
                if (state_ff == RCB_ST_SP)
                    sp_ff <= flash_rdata;
                if (nxt_state == RCB_ST_LOADER && state_ff != RCB_ST_LOADER)
                    loader_ff <= 1'b1;
                if (is_final(nxt_state) && state_ff != nxt_state)
                    done_ff <= 1'b1;
            end
        end
    end

    // flash reads: vector first, then stack pointer word
    assign flash_rd = (state_ff == RCB_ST_VEC) | (state_ff == RCB_ST_SP);
    assign flash_addr = (state_ff == RCB_ST_SP) ? RCB_SP_ADDR : RCB_VEC_ADDR;
    assign rom_remap = remap_ff;
    assign boot_done = done_ff;
    assign boot_loader = loader_ff;
    assign boot_sp = sp_ff;
    assign boot_pc = pc_ff;

    // -----------------------------------------------------------------
    // interrupt: boot done and loader entered, cleared on read
    // -----------------------------------------------------------------
    // one-cycle pulse as the decision settles
    wire ev_done = (state_ff != nxt_state) & is_final(nxt_state) & core_rel;
    wire ev_ldr = ev_done & (nxt_state == RCB_ST_LOADER);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            st_ev_ff <= 2'h0;
        else
            st_ev_ff <= (rd_st ? 2'h0 : st_ev_ff) | {ev_ldr, ev_done};
    end
    assign irq = |(st_ev_ff & mask_ff);

endmodule : rcb_reset_ctrl

// >>> verif/rcb_pin_model.sv
// board side of the reset pin: pull-up when idle, pulled low on a press
module rcb_pin_model
#(
    parameter int MIN_LOW = 4  // shortest low time the board guarantees
)
(
    // clock
    input wire logic clock,
    // press request from the bench
    input wire logic press,
    // reset pin, pulled up when nobody drives it
    output logic ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_ff = 0;  // low cycles still owed after the press ends
    initial ext_reset_n = 1'b1;
    // hold the pin low while pressed and for the minimum width afterwards
    always @(posedge clock)
    begin
        ext_reset_n <= !(press || cnt_ff != 0);
        cnt_ff <= press ? MIN_LOW : (cnt_ff != 0 ? cnt_ff - 1 : 0);
    end
endmodule : rcb_pin_model

// >>> verif/rcb_reset_checker.sv
// watches the reset controller's ports for ordering and latency slips
module rcb_reset_checker
    import rcb_pkg::*;
#(
    parameter int PERIPH_W = 32,  // peripheral reset lines
    parameter int GPIO_W = 64     // selectable boot pins
)
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic rst_n,
    // reset requests
    input wire logic ext_reset_n,
    input wire logic supply_droop_reset,
    input wire logic wdog_reset,
    input wire logic main_oscillator_fail,
    // register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // flash fetch
    input wire logic flash_rd,
    input wire logic [31:0] flash_addr,
    input wire logic [31:0] flash_rdata,
    // reset and boot outputs
    input wire logic core_reset_n,
    input wire logic tap_reset_n,
    input wire logic [PERIPH_W-1:0] periph_reset_n,
    input wire logic rom_remap,
    input wire logic boot_loader,
    input wire logic [31:0] boot_sp
);
    timeunit 1ns;
    timeprecision 1ps;
    // requests that reset core and tap together
    logic any_fault;
    assign any_fault = supply_droop_reset || wdog_reset || main_oscillator_fail;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_fault_resets_all: assert property (any_fault |-> ##[1:3] (!core_reset_n && !tap_reset_n))
        else $error("fault request left core or tap running");
    a_ext_holds_core: assert property (!ext_reset_n |-> ##[1:3] !core_reset_n)
        else $error("reset pin low but core running");
    a_ext_spares_tap: assert property (!ext_reset_n && tap_reset_n && !any_fault |=> tap_reset_n)
        else $error("reset pin reset the tap");
    a_ext_release: assert property ($rose(ext_reset_n) && !any_fault
        |-> !core_reset_n ##1 !core_reset_n ##[1:3] core_reset_n)
        else $error("core release after pin not on the synchroniser count");
    a_periph_with_core: assert property (!core_reset_n |-> periph_reset_n == '0)
        else $error("peripheral out of reset while core held");
    a_remap_in_reset: assert property (!core_reset_n |=> rom_remap)
        else $error("rom not overlaid during core reset");
    a_remap_cleared: assert property ($rose(core_reset_n) |-> ##[1:2] !rom_remap)
        else $error("boot did not clear the rom overlay");
    a_blank_loader: assert property (flash_rd && flash_addr == RCB_VEC_ADDR
        && flash_rdata == RCB_BLANK |-> ##[1:2] boot_loader)
        else $error("blank vector did not enter the loader");
    a_sp_loaded: assert property (flash_rd && flash_addr == RCB_SP_ADDR |=> boot_sp == $past(flash_rdata))
        else $error("stack word not loaded");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside the answer cycle");
endmodule : rcb_reset_checker

bind rcb_reset_ctrl rcb_reset_checker #(.PERIPH_W(PERIPH_W), .GPIO_W(GPIO_W)) rcb_reset_checker_i (
    .clock(clock), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .supply_droop_reset(supply_droop_reset),
    .wdog_reset(wdog_reset), .main_oscillator_fail(main_oscillator_fail), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
    .core_reset_n(core_reset_n), .tap_reset_n(tap_reset_n), .periph_reset_n(periph_reset_n),
    .rom_remap(rom_remap), .boot_loader(boot_loader), .boot_sp(boot_sp));

// >>> verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rcb_pkg::*;
    // stimulus and observed signals
    logic clock, rst_n, press, ext_reset_n, supply_droop_reset, wdog_reset, main_oscillator_fail;
    logic reg_wr, reg_rd, flash_rd, core_reset_n, tap_reset_n, rom_remap, boot_done, boot_loader, irq;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, flash_addr, flash_rdata, boot_sp, boot_pc, vec_word, periph_reset_n;
    logic [63:0] gpio_in;
    int n_mismatch = 0;
    int checked = 0;
    localparam logic [31:0] SP_WORD = 32'h2000_1000;  // stack word kept in flash
    // flash answers in the fetch cycle, junk when idle
    assign flash_rdata = !flash_rd ? ~vec_word : (flash_addr == RCB_VEC_ADDR) ? vec_word : SP_WORD;
    rcb_reset_ctrl rcb_reset_ctrl_i (.clock(clock), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .supply_droop_reset(supply_droop_reset), .wdog_reset(wdog_reset),
        .main_oscillator_fail(main_oscillator_fail), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata), .core_reset_n(core_reset_n),
        .tap_reset_n(tap_reset_n), .periph_reset_n(periph_reset_n), .rom_remap(rom_remap),
        .boot_done(boot_done), .boot_loader(boot_loader), .boot_sp(boot_sp), .boot_pc(boot_pc), .irq(irq));
    rcb_pin_model #(.MIN_LOW(4)) rcb_pin_model_i (.clock(clock), .press(press), .ext_reset_n(ext_reset_n));
    // 50 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // report and end the run
    task automatic close_out();
        $display("tb counts: checked %0d mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // compare one value
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one-cycle write, then an idle edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr
    // one-cycle read, data taken in the answer cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask : rd
    // bounded wait for the boot decision
    task automatic wait_boot();
        for (int i = 0; i < 200 && boot_done !== 1'b1; i++)
            @(posedge clock);
        chk("boot_done", 32'(boot_done), 32'h1);
        if (boot_done !== 1'b1)
            close_out();
        @(posedge clock);
    endtask : wait_boot
    // pulse fault k (droop, wdog, osc) and wait for the new boot
    task automatic pulse_fault(input int k);
        {main_oscillator_fail, wdog_reset, supply_droop_reset} <= 3'b001 << k;
        repeat (2) @(posedge clock);
        #1 chk("tap_reset_n", 32'(tap_reset_n), 32'h0);
        chk("core_reset_n", 32'(core_reset_n), 32'h0);
        @(posedge clock);
        {main_oscillator_fail, wdog_reset, supply_droop_reset} <= 3'b000;
        wait_boot();
    endtask : pulse_fault
    // first boot after power-on
    task automatic t_power_on();
        logic [31:0] d;
        wait_boot();
        rd(RCB_ADDR_CAUSE, d);
        chk("cause", d, 32'h1);
        chk("boot_sp", boot_sp, SP_WORD);
        chk("boot_pc", boot_pc, vec_word);
        chk("boot_loader", 32'(boot_loader), 32'h0);
        chk("rom_remap", 32'(rom_remap), 32'h0);
        rd(RCB_ADDR_STATUS, d);
        chk("status", d, 32'h8 | 32'(RCB_ST_RUN));
        rd(4'hf, d);
        chk("unmapped", d, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        wr(RCB_ADDR_IRQ_MASK, 32'h3);
        #1 chk("irq open", 32'(irq), 32'h1);
        @(posedge clock);
        rd(RCB_ADDR_IRQ_ST, d);
        chk("irq status", d, 32'h1);
        #1 chk("irq cleared", 32'(irq), 32'h0);
        @(posedge clock);
        $display("test power_on done");
    endtask : t_power_on
    // long pin press, then clear one flag
    task automatic t_ext();
        logic [31:0] d;
        press <= 1'b1;
        repeat (8) @(posedge clock);
        press <= 1'b0;
        #1 chk("core_reset_n", 32'(core_reset_n), 32'h0);
        chk("tap_reset_n", 32'(tap_reset_n), 32'h1);
        wait_boot();
        rd(RCB_ADDR_CAUSE, d);
        chk("cause", d, 32'h3);
        wr(RCB_ADDR_CAUSE, 32'hffff_fffd);
        rd(RCB_ADDR_CAUSE, d);
        chk("cause", d, 32'h1);
        $display("test ext done");
    endtask : t_ext
    // the three fault sources and the system request
    task automatic t_faults();
        logic [31:0] d;
        logic [31:0] e = 32'h1;
        int pos[3] = '{RCB_C_DROOP, RCB_C_WDOG, RCB_C_OSC};
        for (int k = 0; k < 3; k++)
        begin
            pulse_fault(k);
            e[pos[k]] = 1'b1;
            rd(RCB_ADDR_CAUSE, d);
            chk("cause", d, e);
        end
        wr(RCB_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 8 && core_reset_n !== 1'b0; i++)
            @(posedge clock);
        chk("core_reset_n", 32'(core_reset_n), 32'h0);
        chk("tap_reset_n", 32'(tap_reset_n), 32'h0);
        @(posedge clock);
        wait_boot();
        rd(RCB_ADDR_CAUSE, d);
        chk("cause", d, e | 32'h8);
        $display("test faults done");
    endtask : t_faults
    // peripheral reset leaves the core running
    task automatic t_periph();
        wr(RCB_ADDR_PERIPH, 32'h5);
        #1 chk("periph_reset_n", periph_reset_n, ~32'h5);
        chk("core_reset_n", 32'(core_reset_n), 32'h1);
        @(posedge clock);
        wr(RCB_ADDR_PERIPH, 32'h0);
        #1 chk("periph_reset_n", periph_reset_n, ~32'h0);
        @(posedge clock);
        $display("test periph done");
    endtask : t_periph
    // boot pin hit, pin miss, disabled pin with blank vector
    task automatic t_boot_pin();
        logic [31:0] d;
        logic [31:0] cfg[3] = '{32'h27, 32'h27, RCB_BOOT_RST};
        logic [63:0] pins[3] = '{64'h200, 64'h0, 64'h200};
        logic [31:0] vec[3] = '{32'h101, 32'h101, RCB_BLANK};
        logic [31:0] want[3] = '{32'h1, 32'h0, 32'h1};
        for (int k = 0; k < 3; k++)
        begin
            wr(RCB_ADDR_BOOT, cfg[k]);
            gpio_in <= pins[k];
            vec_word <= vec[k];
            pulse_fault(1);
            chk("boot_loader", 32'(boot_loader), want[k]);
            rd(RCB_ADDR_IRQ_ST, d);
            chk("irq status", d, 32'h1 | (want[k] << 1));
        end
        $display("test boot_pin done");
    endtask : t_boot_pin
    // main sequence
    initial
    begin
        {rst_n, press, supply_droop_reset, wdog_reset, main_oscillator_fail, reg_wr, reg_rd} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        gpio_in = '0;
        vec_word = 32'h101;
        repeat (5) @(posedge clock);
        chk("core_reset_n", 32'(core_reset_n), 32'h0);
        chk("tap_reset_n", 32'(tap_reset_n), 32'h0);
        rst_n <= 1'b1;
        t_power_on();
        t_ext();
        t_faults();
        t_periph();
        t_boot_pin();
        close_out();
    end
endmodule : tb
